//--- shared/ivp_pkg.sv
// constants, register map and types for the interrupt vector priority unit
package ivp_pkg;
	// source counts: original group, additional group, all
	localparam int N0 = 9;
	localparam int N1 = 6;
	localparam int NSRC = 15;
	localparam int WIN_W = 4;

	// source indices, lowest priority first
	localparam logic [3:0] SRC_TMR1_OVF = 4'h0;
	localparam logic [3:0] SRC_ANALOG7 = 4'h1;
	localparam logic [3:0] SRC_CAP_DATA = 4'h2;
	localparam logic [3:0] SRC_CAP_FULL = 4'h3;
	localparam logic [3:0] SRC_RX_DONE = 4'h4;
	localparam logic [3:0] SRC_TX_DONE = 4'h5;
	localparam logic [3:0] SRC_EXT_PIN = 4'h6;
	localparam logic [3:0] SRC_TMR2_OVF = 4'h7;
	localparam logic [3:0] SRC_TMR2_CROSS = 4'h8;
	localparam logic [3:0] SRC_CAP_QUARTER = 4'h9;
	localparam logic [3:0] SRC_TMR2_SNAP = 4'ha;
	localparam logic [3:0] SRC_EXT2_PIN = 4'hb;
	localparam logic [3:0] SRC_UNIMPL = 4'hc;
	localparam logic [3:0] SRC_TRAP = 4'hd;
	localparam logic [3:0] SRC_NMI = 4'he;

	// sources that no mask bit or global enable can hold off from int_req; irq still follows their mask bits
	localparam logic [14:0] UNMASKABLE = 15'h7000;

	// vector locations
	localparam logic [15:0] VEC_TMR_OVF = 16'h2000;
	localparam logic [15:0] VEC_ANALOG7 = 16'h2002;
	localparam logic [15:0] VEC_CAP_DATA = 16'h2004;
	localparam logic [15:0] VEC_CAP_FULL = 16'h2006;
	localparam logic [15:0] VEC_RX_DONE = 16'h2008;
	localparam logic [15:0] VEC_TX_DONE = 16'h200a;
	localparam logic [15:0] VEC_EXT_PIN = 16'h200e;
	localparam logic [15:0] VEC_TMR2_ALT = 16'h2038;
	localparam logic [15:0] VEC_TMR2_CROSS = 16'h2030;
	localparam logic [15:0] VEC_CAP_QUARTER = 16'h2032;
	localparam logic [15:0] VEC_TMR2_SNAP = 16'h2034;
	localparam logic [15:0] VEC_EXT2_PIN = 16'h2036;
	localparam logic [15:0] VEC_UNIMPL = 16'h2012;
	localparam logic [15:0] VEC_TRAP = 16'h2010;
	localparam logic [15:0] VEC_NMI = 16'h203e;

	// register byte offsets
	localparam logic [7:0] OFS_PEND0 = 8'h00;
	localparam logic [7:0] OFS_MASK0 = 8'h04;
	localparam logic [7:0] OFS_PEND1 = 8'h08;
	localparam logic [7:0] OFS_MASK1 = 8'h0c;
	localparam logic [7:0] OFS_CLR0 = 8'h10;
	localparam logic [7:0] OFS_CLR1 = 8'h14;
	localparam logic [7:0] OFS_CONFIG = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;

	// config fields and reset values
	localparam int CFG_SEPARATE = 0;
	localparam int CFG_TMR2_ALT = 1;
	localparam logic [1:0] CFG_RESET = 2'h0;
	localparam logic [8:0] MASK0_RESET = 9'h000;
	localparam logic [5:0] MASK1_RESET = 6'h00;

	// capture queue levels
	localparam logic [3:0] QUEUE_QUARTER = 4'h4;
	localparam logic [3:0] QUEUE_FULL = 4'h6;

	// timer two half-range boundary
	localparam logic [15:0] TMR2_BELOW = 16'h7fff;
	localparam logic [15:0] TMR2_ABOVE = 16'h8000;

	// timing, in state times, one state per clock
	localparam int CLK_NS = 10;
	localparam int STATE_NS = 10;
	localparam int RESP_STATES = 18;
	localparam int NORM_STATES = 39;
	localparam int LATENCY_STATES = 61;
	localparam int RESP_CYCLES = (RESP_STATES * STATE_NS + CLK_NS - 1) / CLK_NS;
	localparam int LATENCY_CYCLES = (LATENCY_STATES * STATE_NS) / CLK_NS;
	localparam int CNT_W = 7;

	typedef enum logic [1:0] {
		IVP_IDLE = 2'b00,
		IVP_RESP = 2'b01,
		IVP_VEC = 2'b10
	} ivp_state_type;
endpackage

//--- shared/ivp_arb_if.sv
// signals between the controller and its priority arbiter
`timescale 1ns/1ns
`default_nettype none
interface ivp_arb_if;
	logic [14:0] enabled;
	logic separate;
	logic tmr2_alt;
	logic any;
	logic [3:0] win;
	logic [15:0] vector;
	modport arb (input enabled, input separate, input tmr2_alt,
		output any, output win, output vector);
	modport ctl (output enabled, output separate, output tmr2_alt,
		input any, input win, input vector);
endinterface
`default_nettype wire

//--- rtl/ivp_arbiter.sv
// priority arbiter and vector lookup for the interrupt unit
`timescale 1ns/1ns
`default_nettype none
module ivp_arbiter (
	ivp_arb_if.arb bus
);
	// vector of one source under the current sharing choice
	function automatic logic [15:0] vec_of(input logic [3:0] idx,
		input logic sep, input logic alt);
		logic [15:0] v;
		v = ivp_pkg::VEC_TMR_OVF;
		case (idx)
			ivp_pkg::SRC_ANALOG7: v = ivp_pkg::VEC_ANALOG7;
			ivp_pkg::SRC_CAP_DATA: v = ivp_pkg::VEC_CAP_DATA;
			ivp_pkg::SRC_CAP_FULL: begin
				v = sep ? ivp_pkg::VEC_CAP_FULL : ivp_pkg::VEC_CAP_DATA;
			end
			ivp_pkg::SRC_RX_DONE: v = ivp_pkg::VEC_RX_DONE;
			ivp_pkg::SRC_TX_DONE: begin
				v = sep ? ivp_pkg::VEC_TX_DONE : ivp_pkg::VEC_RX_DONE;
			end
			ivp_pkg::SRC_EXT_PIN: begin
				v = sep ? ivp_pkg::VEC_EXT_PIN : ivp_pkg::VEC_ANALOG7;
			end
			ivp_pkg::SRC_TMR2_OVF: begin
				v = (sep && alt) ? ivp_pkg::VEC_TMR2_ALT : ivp_pkg::VEC_TMR_OVF;
			end
			ivp_pkg::SRC_TMR2_CROSS: v = ivp_pkg::VEC_TMR2_CROSS;
			ivp_pkg::SRC_CAP_QUARTER: v = ivp_pkg::VEC_CAP_QUARTER;
			ivp_pkg::SRC_TMR2_SNAP: v = ivp_pkg::VEC_TMR2_SNAP;
			ivp_pkg::SRC_EXT2_PIN: v = ivp_pkg::VEC_EXT2_PIN;
			ivp_pkg::SRC_UNIMPL: v = ivp_pkg::VEC_UNIMPL;
			ivp_pkg::SRC_TRAP: v = ivp_pkg::VEC_TRAP;
			ivp_pkg::SRC_NMI: v = ivp_pkg::VEC_NMI;
			default: v = ivp_pkg::VEC_TMR_OVF;
		endcase
		return v;
	endfunction

	// highest index wins; additional sources sit above the original ones
	always_comb begin
		bus.win = 4'h0;
		for (int i = 0; i < ivp_pkg::NSRC; i++) begin
			if (bus.enabled[i]) begin
				bus.win = 4'(i);
			end
		end
	end

	assign bus.any = |bus.enabled;
	assign bus.vector = vec_of(bus.win, bus.separate, bus.tmr2_alt);
endmodule
`default_nettype wire

//--- rtl/ivp_top.sv
// interrupt vector priority unit with its AHB-Lite register slave
//
// How it works
// - legacy shared pairs, or separate vectors
// - six additional interrupt sources
// - nmi fetches vector at 203E
// - second pending and mask registers
// - originals keep order, additions rank higher
// - push/pop all saves both masks
// - listed ops hold off one instruction
// - latency past 61 states flagged, 18 response
// - capture data and queue-six, shareable
// - capture queue four-entry interrupt
// - receive/transmit share or split vector
// - timer two overflow and boundary crossing
// - timer two overflow vector selectable in separate mode
// - timer two snapshot raises interrupt
`timescale 1ns/1ns
`default_nettype none
module ivp_top #(
	parameter int QW = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic tmr1_ovf_evt,
	input wire logic analog_channel_seven_input,
	input wire logic cap_data_evt,
	input wire logic [QW-1:0] cap_queue_depth,
	input wire logic receive_done_flag,
	input wire logic transmit_done_flag,
	input wire logic external_irq_line,
	input wire logic tmr2_ovf_evt,
	input wire logic [15:0] tmr2_count,
	input wire logic second_timer_snapshot,
	input wire logic second_external_irq,
	input wire logic unimpl_opcode_evt,
	input wire logic trap_evt,
	input wire logic nmi_evt,
	input wire logic global_ie,
	input wire logic instr_done,
	input wire logic inhibit_op,
	input wire logic int_ack,
	input wire logic pop_all_state_op,
	input wire logic [8:0] restore_mask0,
	input wire logic [5:0] restore_mask1,
	output logic [8:0] saved_mask0,
	output logic [5:0] saved_mask1,
	output logic int_req,
	output logic resp_busy,
	output logic vector_valid,
	output logic [15:0] vector_addr,
	output logic irq
);
	ivp_arb_if arb_bus ();

	logic [8:0] pend0;
	logic [8:0] mask0;
	logic [5:0] pend1;
	logic [5:0] mask1;
	logic [1:0] config_bits;
	logic [QW-1:0] depth_prev;
	logic [15:0] tmr2_prev;
	logic inhibit_hold;
	logic latency_over;
	ivp_pkg::ivp_state_type state;
	logic [ivp_pkg::CNT_W-1:0] resp_cnt;
	logic [ivp_pkg::CNT_W-1:0] wait_cnt;
	logic [3:0] win_q;
	logic [15:0] vec_q;

	// bus address phase capture for the write data phase
	logic wr_pend;
	logic [7:0] wr_addr;

	// address phase decode and data phase write strobes
	wire logic addr_phase = hsel && htrans[1] && hready;
	wire logic [7:0] a_ofs = haddr[7:0];
	wire logic [15:0] sw_clr = (wr_pend && wr_addr == ivp_pkg::OFS_CLR0) ?
		{7'h00, hwdata[8:0]} : (wr_pend && wr_addr == ivp_pkg::OFS_CLR1) ?
		{7'h00, 3'h0, hwdata[5:0]} : 16'h0000;
	wire logic clr0_hit = wr_pend && wr_addr == ivp_pkg::OFS_CLR0;
	wire logic clr1_hit = wr_pend && wr_addr == ivp_pkg::OFS_CLR1;
	wire logic mask0_wr = wr_pend && wr_addr == ivp_pkg::OFS_MASK0;
	wire logic mask1_wr = wr_pend && wr_addr == ivp_pkg::OFS_MASK1;
	wire logic cfg_wr = wr_pend && wr_addr == ivp_pkg::OFS_CONFIG;

	// capture queue level crossings, caught once per upward pass
	// four-entry event
	wire logic quarter_evt = cap_queue_depth >= QW'(ivp_pkg::QUEUE_QUARTER)
		&& depth_prev < QW'(ivp_pkg::QUEUE_QUARTER);
	wire logic full_evt = cap_queue_depth >= QW'(ivp_pkg::QUEUE_FULL)
		&& depth_prev < QW'(ivp_pkg::QUEUE_FULL);

	// half-range crossing in either counting direction
	// boundary crossing detect
	wire logic cross_evt =
		(tmr2_prev == ivp_pkg::TMR2_BELOW && tmr2_count == ivp_pkg::TMR2_ABOVE)
		|| (tmr2_prev == ivp_pkg::TMR2_ABOVE && tmr2_count == ivp_pkg::TMR2_BELOW);

	// event set vectors for both pending registers
	wire logic [8:0] set0 = {cross_evt, tmr2_ovf_evt, external_irq_line,
		transmit_done_flag, receive_done_flag, full_evt, cap_data_evt,
		analog_channel_seven_input, tmr1_ovf_evt};
	wire logic [5:0] set1 = {nmi_evt, trap_evt, unimpl_opcode_evt,
		second_external_irq, second_timer_snapshot, quarter_evt};

	// clear of the acknowledged source only
	wire logic take = state == ivp_pkg::IVP_IDLE && int_ack && int_req;
	wire logic [14:0] ack_clr = take ? (15'h0001 << arb_bus.win) : 15'h0000;

	// enables: mask bits, unmaskable sources always pass
	wire logic [14:0] pend_all = {pend1, pend0};
	wire logic [14:0] mask_all = {mask1, mask0} | ivp_pkg::UNMASKABLE;
	assign arb_bus.enabled = pend_all & mask_all;
	assign arb_bus.separate = config_bits[ivp_pkg::CFG_SEPARATE];
	assign arb_bus.tmr2_alt = config_bits[ivp_pkg::CFG_TMR2_ALT];

	// request to the sequencer; inhibit covers the retiring instruction
	// block ack one instruction
	wire logic inhibited = inhibit_hold || (instr_done && inhibit_op);
	wire logic urgent = |(arb_bus.enabled & ivp_pkg::UNMASKABLE);
	assign int_req = state == ivp_pkg::IVP_IDLE && !inhibited
		&& (urgent || (global_ie && arb_bus.any));

	assign irq = |({pend1, pend0} & {mask1, mask0});
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign resp_busy = state != ivp_pkg::IVP_IDLE; // vector step is busy too
	assign saved_mask0 = mask0;
	assign saved_mask1 = mask1;

	// read mux for the address phase
	wire logic [31:0] rd_mux =
		(a_ofs == ivp_pkg::OFS_PEND0) ? {23'h0, pend0} :
		(a_ofs == ivp_pkg::OFS_MASK0) ? {23'h0, mask0} :
		(a_ofs == ivp_pkg::OFS_PEND1) ? {26'h0, pend1} :
		(a_ofs == ivp_pkg::OFS_MASK1) ? {26'h0, mask1} :
		(a_ofs == ivp_pkg::OFS_CONFIG) ? {30'h0, config_bits} :
		(a_ofs == ivp_pkg::OFS_STATUS) ?
		{24'h0, latency_over, inhibit_hold, state, win_q} : 32'h0000_0000;

	ivp_arbiter u_arb (
		.bus(arb_bus.arb)
	);

	// bus slave: writes land in the data phase, reads are registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend <= addr_phase && hwrite;
			wr_addr <= a_ofs;
			if (addr_phase && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// pending flags: a new event wins over any clear in the same cycle
	// second pending register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend0 <= 9'h000;
			pend1 <= 6'h00;
		end else begin
			pend0 <= (pend0 & ~(ack_clr[8:0] | (clr0_hit ? sw_clr[8:0] : 9'h000)))
				| set0;
			pend1 <= (pend1 & ~(ack_clr[14:9] | (clr1_hit ? sw_clr[5:0] : 6'h00)))
				| set1;
		end
	end

	// masks and config; a pop-all restore outranks a bus write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask0 <= ivp_pkg::MASK0_RESET;
			mask1 <= ivp_pkg::MASK1_RESET;
			config_bits <= ivp_pkg::CFG_RESET;
		end else begin
			if (pop_all_state_op) begin
				mask0 <= restore_mask0;
				mask1 <= restore_mask1;
			end else begin
				if (mask0_wr) begin
					mask0 <= hwdata[8:0];
				end
				if (mask1_wr) begin
					mask1 <= hwdata[5:0];
				end
			end
			if (cfg_wr) begin
				config_bits <= hwdata[1:0];
			end
		end
	end

	// history for level and boundary detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			depth_prev <= '0;
			tmr2_prev <= 16'h0000;
		end else begin
			depth_prev <= cap_queue_depth;
			tmr2_prev <= tmr2_count;
		end
	end

	// inhibit lasts until the following instruction retires
	// hold across next instruction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			inhibit_hold <= 1'b0;
		end else if (instr_done) begin
			inhibit_hold <= inhibit_op;
		end
	end

	// response sequence: fixed response time then one vector strobe
	// bounded response
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ivp_pkg::IVP_IDLE;
			resp_cnt <= '0;
			win_q <= 4'h0;
			vec_q <= 16'h0000;
			vector_valid <= 1'b0;
			vector_addr <= 16'h0000;
		end else begin
			vector_valid <= 1'b0;
			case (state)
				ivp_pkg::IVP_IDLE: begin
					if (take) begin
						win_q <= arb_bus.win;
						vec_q <= arb_bus.vector;
						// the vector step is the last of the response states
						resp_cnt <= ivp_pkg::CNT_W'(ivp_pkg::RESP_CYCLES - 2);
						state <= ivp_pkg::IVP_RESP;
					end
				end
				ivp_pkg::IVP_RESP: begin
					if (resp_cnt == '0) begin
						state <= ivp_pkg::IVP_VEC;
					end else begin
						resp_cnt <= resp_cnt - 1'b1;
					end
				end
				ivp_pkg::IVP_VEC: begin
					vector_valid <= 1'b1;
					vector_addr <= vec_q;
					state <= ivp_pkg::IVP_IDLE;
				end
				default: state <= ivp_pkg::IVP_IDLE;
			endcase
		end
	end

	// latency watch: counts request-to-vector; flags runs past the limit
	// since the core may sit in a long instruction, this only reports
	// latency limit check
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_cnt <= '0;
			latency_over <= 1'b0;
		end else begin
			if (vector_valid || (state == ivp_pkg::IVP_IDLE && !arb_bus.any)) begin
				wait_cnt <= '0;
			end else if (wait_cnt != '1) begin
				wait_cnt <= wait_cnt + 1'b1;
			end
			if (wait_cnt == ivp_pkg::CNT_W'(ivp_pkg::LATENCY_CYCLES)) begin
				latency_over <= 1'b1;
			end else if (cfg_wr && hwdata[7]) begin
				latency_over <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/ivp_monitor.sv
// concurrent checks on the interrupt unit's top-level ports
`timescale 1ns/1ns
`default_nettype none
module ivp_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic int_req,
	input wire logic int_ack,
	input wire logic resp_busy,
	input wire logic vector_valid,
	input wire logic [15:0] vector_addr,
	input wire logic instr_done,
	input wire logic inhibit_op,
	input wire logic pop_all_state_op,
	input wire logic [8:0] restore_mask0,
	input wire logic [5:0] restore_mask1,
	input wire logic [8:0] saved_mask0,
	input wire logic [5:0] saved_mask1,
	input wire logic irq
);
	// single clock domain, so clock and reset are given once
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_zero_wait;
		hreadyout && !hresp;
	endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("slave stalled");

	property p_vec_time;
		int_req && int_ack |-> ##19 vector_valid;
	endproperty
	a_vec_time: assert property (p_vec_time) else $error("vector late");

	property p_busy_run;
		int_req && int_ack |=> resp_busy [*8];
	endproperty
	a_busy_run: assert property (p_busy_run) else $error("busy dropped");

	property p_vec_pulse;
		vector_valid |=> !vector_valid;
	endproperty
	a_vec_pulse: assert property (p_vec_pulse) else $error("valid too long");

	// a second request must never be offered while one is in flight
	property p_busy_quiet;
		resp_busy |-> !int_req;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("req while busy");

	property p_end_vec;
		$fell(resp_busy) |-> vector_valid;
	endproperty
	a_end_vec: assert property (p_end_vec) else $error("busy ended, no vector");

	property p_vec_page;
		vector_valid |-> vector_addr[15:6] == 10'h080;
	endproperty
	a_vec_page: assert property (p_vec_page) else $error("vector off table");

	property p_inhibit;
		instr_done && inhibit_op |=> !int_req [*2];
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("req not held off");

	property p_restore;
		pop_all_state_op |=> saved_mask0 == $past(restore_mask0)
			&& saved_mask1 == $past(restore_mask1);
	endproperty
	a_restore: assert property (p_restore) else $error("masks not restored");

	property p_masked_quiet;
		saved_mask0 == 9'h000 && saved_mask1 == 6'h00 |-> !irq;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("irq unmasked");
endmodule
bind ivp_top ivp_monitor u_ivp_monitor (.hclk, .hresetn, .hreadyout, .hresp,
	.int_req, .int_ack, .resp_busy, .vector_valid, .vector_addr, .instr_done,
	.inhibit_op, .pop_all_state_op, .restore_mask0, .restore_mask1,
	.saved_mask0, .saved_mask1, .irq);
`default_nettype wire

//--- verif/ivp_core_model.sv
// core sequencer model: retires instructions and acknowledges requests
`timescale 1ns/1ns
`default_nettype none
module ivp_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic int_req,
	input wire logic vector_valid,
	input wire logic go,
	input wire logic [3:0] delay,
	input wire logic inh,
	output logic int_ack,
	output logic instr_done,
	output logic inhibit_op
);
	logic waiting;
	logic inh_pend;
	logic [3:0] cnt;
	logic [1:0] ph;

	// one instruction every three cycles, never back to back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph <= 2'd0;
			instr_done <= 1'b0;
			inhibit_op <= 1'b0;
			inh_pend <= 1'b0;
			int_ack <= 1'b0;
			waiting <= 1'b0;
			cnt <= 4'h0;
		end else begin
			ph <= (ph == 2'd2) ? 2'd0 : ph + 2'd1;
			instr_done <= (ph == 2'd2);
			inhibit_op <= (ph == 2'd2) && inh_pend;
			if (inh)
				inh_pend <= 1'b1;
			else if (ph == 2'd2)
				inh_pend <= 1'b0;
			if (vector_valid)
				waiting <= 1'b0;
			// ack held until it meets a live request, else it would be lost
			if (int_ack) begin
				if (int_req) begin
					int_ack <= 1'b0;
					waiting <= 1'b1;
				end
			end else if (go && int_req && !waiting) begin
				if (cnt >= delay) begin
					int_ack <= 1'b1;
					cnt <= 4'h0;
				end else
					cnt <= cnt + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the interrupt vector priority unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [14:0] ev = 15'h0000;
	logic [3:0] depth = 4'h0;
	logic [15:0] t2 = 16'h7fff;
	logic global_ie = 1'b1;
	logic pop_all = 1'b0;
	logic [8:0] rm0 = 9'h000;
	logic [5:0] rm1 = 6'h00;
	logic go = 1'b0;
	logic inh = 1'b0;
	logic [3:0] delay = 4'h0;
	logic [31:0] hrdata, rd_val, r;
	logic hreadyout, hresp, int_req, int_ack, instr_done, inhibit_op;
	logic vector_valid, irq;
	logic [15:0] vector_addr;
	int errors = 0;
	int comparisons = 0;
	int seed = 10832;
	logic [39:0] rq[$];
	logic [15:0] vq[$];
	event rd_ev;

	always #5 hclk = ~hclk;

	ivp_top #(.QW(4)) u_ivp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tmr1_ovf_evt(ev[0]),
		.analog_channel_seven_input(ev[1]), .cap_data_evt(ev[2]),
		.cap_queue_depth(depth), .receive_done_flag(ev[4]),
		.transmit_done_flag(ev[5]), .external_irq_line(ev[6]),
		.tmr2_ovf_evt(ev[7]), .tmr2_count(t2), .second_timer_snapshot(ev[10]),
		.second_external_irq(ev[11]), .unimpl_opcode_evt(ev[12]),
		.trap_evt(ev[13]), .nmi_evt(ev[14]), .global_ie(global_ie),
		.instr_done(instr_done), .inhibit_op(inhibit_op), .int_ack(int_ack),
		.pop_all_state_op(pop_all), .restore_mask0(rm0), .restore_mask1(rm1),
		.saved_mask0(), .saved_mask1(), .int_req(int_req), .resp_busy(),
		.vector_valid(vector_valid), .vector_addr(vector_addr), .irq(irq));

	ivp_core_model u_ivp_core_model (.hclk(hclk), .hresetn(hresetn),
		.int_req(int_req), .vector_valid(vector_valid), .go(go),
		.delay(delay), .inh(inh), .int_ack(int_ack),
		.instr_done(instr_done), .inhibit_op(inhibit_op));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one single-word transfer; waits on hready in both phases
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd_val = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back({a, e});
		bus(1'b0, a, 32'h0000_0000);
		-> rd_ev;
	endtask

	task automatic fire(input logic [14:0] m);
		@(posedge hclk);
		ev <= m;
		if (m[9]) depth <= 4'h4;
		if (m[8]) t2 <= ~t2;
		@(posedge hclk);
		ev <= 15'h0000;
		if (m[3]) depth <= 4'h6;
		@(posedge hclk);
		depth <= 4'h0;
	endtask

	task automatic drain;
		for (int k = 0; k < 4000 && vq.size() != 0; k++) @(posedge hclk);
		go <= 1'b0;
		chk("vectors left", 32'h0000_0000, 32'(vq.size()));
	endtask

	function automatic logic [15:0] vec_of(input int i, input logic [1:0] c);
		case (i)
			0: vec_of = 16'h2000;
			1: vec_of = 16'h2002;
			2: vec_of = 16'h2004;
			3: vec_of = c[0] ? 16'h2006 : 16'h2004;
			4: vec_of = 16'h2008;
			5: vec_of = c[0] ? 16'h200a : 16'h2008;
			6: vec_of = c[0] ? 16'h200e : 16'h2002;
			7: vec_of = (c == 2'h3) ? 16'h2038 : 16'h2000;
			8: vec_of = 16'h2030;
			9: vec_of = 16'h2032;
			10: vec_of = 16'h2034;
			11: vec_of = 16'h2036;
			12: vec_of = 16'h2012;
			13: vec_of = 16'h2010;
			default: vec_of = 16'h203e;
		endcase
	endfunction

	// read checker: oldest note against the data just taken
	always begin
		@(rd_ev);
		chk($sformatf("reg %h", rq[0][39:32]), rq[0][31:0], rd_val);
		void'(rq.pop_front());
	end

	// vector checker: an unexpected vector compares against all ones
	always @(posedge hclk) begin
		if (vector_valid === 1'b1) begin
			chk("vector", (vq.size() != 0) ? {16'h0000, vq[0]} : 32'hffff_ffff,
				{16'h0000, vector_addr});
			if (vq.size() != 0) void'(vq.pop_front());
		end
	end

	// main sequence
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 0; a <= 32; a += 4)
			if (a != 16 && a != 20) rd(8'(a), 32'h0000_0000);
		$display("test reset done");
		r = $random(seed);
		@(posedge hclk);
		pop_all <= 1'b1;
		rm0 <= r[8:0];
		rm1 <= r[14:9];
		@(posedge hclk);
		pop_all <= 1'b0;
		rd(ivp_pkg::OFS_MASK0, {23'h00_0000, r[8:0]});
		rd(ivp_pkg::OFS_MASK1, {26'h000_0000, r[14:9]});
		$display("test restore done");
		r = $random(seed);
		bus(1'b1, ivp_pkg::OFS_MASK0, r);
		bus(1'b1, ivp_pkg::OFS_MASK1, r);
		bus(1'b1, ivp_pkg::OFS_PEND0, 32'hffff_ffff);
		bus(1'b1, 8'h20, 32'hffff_ffff);
		rd(ivp_pkg::OFS_MASK0, r & 32'h0000_01ff);
		rd(ivp_pkg::OFS_MASK1, r & 32'h0000_003f);
		rd(ivp_pkg::OFS_PEND0, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		fire(15'h7fff);
		rd(ivp_pkg::OFS_PEND0, 32'h0000_01ff);
		rd(ivp_pkg::OFS_PEND1, 32'h0000_003f);
		chk("irq", {31'h0, (|r[8:0]) | (|r[5:0])}, {31'h0, irq});
		bus(1'b1, ivp_pkg::OFS_CLR0, 32'h0000_01ff);
		bus(1'b1, ivp_pkg::OFS_CLR1, 32'h0000_003f);
		rd(ivp_pkg::OFS_PEND0, 32'h0000_0000);
		rd(ivp_pkg::OFS_PEND1, 32'h0000_0000);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		$display("test mask done");
		bus(1'b1, ivp_pkg::OFS_MASK0, 32'h0000_01ff);
		bus(1'b1, ivp_pkg::OFS_MASK1, 32'h0000_003f);
		// every mode pairing, each with a random acknowledge delay
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, ivp_pkg::OFS_CONFIG, 32'(c));
			fire(15'h7fff);
			for (int i = 14; i >= 0; i--) vq.push_back(vec_of(i, 2'(c)));
			r = $random(seed);
			delay <= r[3:0];
			go <= 1'b1;
			drain;
			rd(ivp_pkg::OFS_PEND0, 32'h0000_0000);
			rd(ivp_pkg::OFS_PEND1, 32'h0000_0000);
		end
		$display("test priority done");
		// maskable quarter held off by the global enable, nmi is not
		global_ie <= 1'b0;
		fire(15'h4200);
		@(posedge hclk);
		inh <= 1'b1;
		@(posedge hclk);
		inh <= 1'b0;
		repeat (6) @(posedge hclk);
		vq.push_back(16'h203e);
		go <= 1'b1;
		drain;
		rd(ivp_pkg::OFS_PEND1, 32'h0000_0001);
		global_ie <= 1'b1;
		vq.push_back(16'h2032);
		go <= 1'b1;
		drain;
		$display("test inhibit done");
		results;
	end

	// about 2000 cycles are expected; allow more than ten times that
	initial begin
		#400000;
		errors++;
		$display("timeout");
		results;
	end

	task automatic results;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
endmodule
`default_nettype wire
